// ### core/redriver_output_regs.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the redriver output control block.
 * assumes: included by design file and testbench, no other dependencies.
 */
`ifndef REDRIVER_OUTPUT_REGS_SVH
`define REDRIVER_OUTPUT_REGS_SVH

// register offsets (word index on the plain register port)
`define OFS_CTRL        4'h0
`define OFS_TERM        4'h1
`define OFS_SLEW        4'h2
`define OFS_STATUS      4'h3
`define OFS_SETTINGS    4'h4

// control register fields
`define CTRL_STBY_INH   0
`define CTRL_AC_BIT     1
`define CTRL_LEG_AUTO   2
`define CTRL_PDOWN      3
`define CTRL_RESET      8'h08

// slew register fields
`define SLEW_CLK_LSB    0
`define EDGE_3G_LSB     3
`define EDGE_6G_LSB     6
`define SLEW_HR_LSB     9
`define SLEW_RESET      12'h000

// term register reset
`define TERM_RESET      2'h2

// activity filter: time the synchronised detect must hold stable
`define DET_FILTER_NS   400
`define CLK_PERIOD_NS   100

`endif

// ### core/redriver_output_pkg.sv
/*
 * types shared by the redriver output control block.
 * assumes: the register header is on the include path.
 */
package redriver_output_pkg;

    // link generation of the current link
    typedef enum logic [1:0] {
        LINK_V14 = 2'h0,
        LINK_V20 = 2'h1,
        LINK_V21 = 2'h2
    } link_ver_type;

    // source termination choices
    typedef enum logic [2:0] {
        TERM_OPEN   = 3'h0,
        TERM_P300   = 3'h1,
        TERM_P100   = 3'h2,
        TERM_V150   = 3'h3,
        TERM_V50    = 3'h4
    } term_type;

    // emphasis settings driven to the analog lanes
    typedef enum logic [2:0] {
        EMPH_0DB    = 3'h0,
        EMPH_PRE35  = 3'h1,
        EMPH_PRE60  = 3'h2,
        EMPH_DE25   = 3'h3,
        EMPH_DE35   = 3'h4,
        EMPH_DE37   = 3'h5,
        EMPH_DE46   = 3'h6
    } emph_type;

    // four-level strap pin
    typedef enum logic [1:0] {
        LVL_LOW   = 2'h0,
        LVL_R     = 2'h1,
        LVL_F     = 2'h2,
        LVL_HIGH  = 2'h3
    } level4_type;

    // standby machine, one-hot
    typedef enum logic [2:0] {
        ST_POWERDOWN = 3'b001,
        ST_STANDBY   = 3'b010,
        ST_ACTIVE    = 3'b100
    } stby_state_type;

    // strap pins grouped together
    typedef struct packed {
        logic       acCoupleStrap;
        logic       legacyTermStrap;
        level4_type emphasisStrap;
        level4_type linearityStrap;
    } strap_type;

    // link status from the snoop and clock-rate logic
    typedef struct packed {
        link_ver_type linkVer;
        logic         laneSwap;
        logic         limitedMode;
        logic [1:0]   snoopedFfeLevel;
        logic         belowOpenLimit;
        logic         aboveTerm300Limit;
    } link_info_type;

    // settings driven to the analog output stage
    typedef struct packed {
        logic       acBias;
        term_type   term;
        emph_type   dataEmph;
        emph_type   clkEmph;
        logic [2:0] slewClk;
        logic [2:0] slewData;
        logic       slewAdjust;
        logic [2:0] adaptiveEqOffset;
    } out_cfg_type;

endpackage

// ### core/redriver_output_control.sv
/*
 * redriver output control: standby and activity detect, signal-present
 * indicator, coupling, termination, slew and emphasis decoding.
 * assumes: straps and activity-detect are asynchronous pins; link info
 * comes from snoop logic on clk; registers reached over a plain port.
 */
// Contract
// - no swap: watch clock lane old, lane2 new
// - swap: watch clock lane new, lane2 old
// - activity wakes device, loss returns to standby
// - standby holds all output lanes high impedance
// - standby on at reset; inhibit bit disables
// - indicator low when active with standby on, released otherwise
// - coupling from strap or bit sets bias
// - strap dc: v2 100 ohm, v1.4 by strap
// - strap ac: v1.4 150, v2 50 to supply
// - strap low v1.4: open or 300 by frequency
// - register dc term code decode, auto mode
// - legacy auto bit forces 300 on v1.4
// - register ac term code decode
// - slew fixed by strap, fields in limited mode
// - emphasis data lanes, limited only, clk in frl
// - strap emphasis levels on older links
// - frl ffe level 0/1 gives -2.5/-3.5
// - frl ffe level 2/3 gives -3.7/-4.6
// - linearity strap F or high enables adaptive eq offset, emphasis strap picks it
// - high legacy strap forces 300 on v1.4 in strap mode with dc coupling
`timescale 1ns/1ps
`default_nettype none
`include "redriver_output_regs.svh"

module redriver_output_control
    import redriver_output_pkg::*;
#(
    parameter int LANES = 4
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // mode and pins
    input  wire logic                regMode,
    input  wire strap_type           straps,
    input  wire logic                clkLaneActive,
    input  wire logic                data_lane2_in,
    input  wire link_info_type       linkInfo,
    // register port
    input  wire logic [3:0]          regAddr,
    input  wire logic [15:0]         regWrData,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [15:0]         regRdData,
    // analog controls
    output out_cfg_type              outCfg,
    output logic      [LANES-1:0]    laneOutEn,
    // open-drain indicator
    output logic                     signal_present_flag_out,
    output logic                     signal_present_flag_oe
);

    localparam int FILTER_CYC =
        (`DET_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    // whole module state
    typedef struct packed {
        logic [2:0]     syncClk;
        logic [2:0]     syncD2;
        logic [2:0]     syncAc;
        logic [2:0]     syncLeg;
        logic           clkQ;
        logic           d2Q;
        logic           acQ;
        logic           legQ;
        logic [3:0]     filtCnt;
        logic           actFilt;
        stby_state_type state;
        logic [7:0]     ctrl;
        logic [1:0]     termCode;
        logic [11:0]    slew;
        logic [15:0]    rdData;
        out_cfg_type    cfg;
        logic [LANES-1:0] laneEn;
        logic           flagOe;
    } state_type;

    state_type cur;
    state_type next_cur;

    logic           rawAct;
    logic           stbyEnabled;
    logic           acSel;
    logic           legSel;
    term_type       termSel;
    emph_type       emphSel;
    logic [2:0]     eqOffSel;

    // next-state logic
    always_comb begin
        next_cur = cur;
        // three-stage syncs; second and third must agree
        next_cur.syncClk = {cur.syncClk[1:0], clkLaneActive};
        next_cur.syncD2  = {cur.syncD2[1:0], data_lane2_in};
        next_cur.syncAc  = {cur.syncAc[1:0], straps.acCoupleStrap};
        next_cur.syncLeg = {cur.syncLeg[1:0], straps.legacyTermStrap};
        // a pin change counts once stages two and three agree,
        // so one late-settling sample never reaches the decode
        if (cur.syncClk[2] == cur.syncClk[1]) begin
            next_cur.clkQ = cur.syncClk[2];
        end
        if (cur.syncD2[2] == cur.syncD2[1]) begin
            next_cur.d2Q = cur.syncD2[2];
        end
        if (cur.syncAc[2] == cur.syncAc[1]) begin
            next_cur.acQ = cur.syncAc[2];
        end
        if (cur.syncLeg[2] == cur.syncLeg[1]) begin
            next_cur.legQ = cur.syncLeg[2];
        end

        // monitored lane choice
        if (linkInfo.laneSwap) begin
            rawAct = (linkInfo.linkVer == LINK_V21)
                ? cur.clkQ : cur.d2Q;
        end else begin
            rawAct = (linkInfo.linkVer == LINK_V21)
                ? cur.d2Q : cur.clkQ;
        end

        // filter: level must hold FILTER_CYC cycles to count
        if (rawAct == cur.actFilt) begin
            next_cur.filtCnt = 4'h0;
        end else if (cur.filtCnt == 4'(FILTER_CYC - 1)) begin
            next_cur.filtCnt = 4'h0;
            next_cur.actFilt = rawAct;
        end else begin
            next_cur.filtCnt = cur.filtCnt + 4'h1;
        end

        stbyEnabled = !(regMode && cur.ctrl[`CTRL_STBY_INH]);

        // standby machine
        case (cur.state)
            ST_POWERDOWN: begin
                if (!(regMode && cur.ctrl[`CTRL_PDOWN])) begin
                    next_cur.state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (regMode && cur.ctrl[`CTRL_PDOWN]) begin
                    next_cur.state = ST_POWERDOWN;
                end else if (cur.actFilt || !stbyEnabled) begin
                    next_cur.state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (regMode && cur.ctrl[`CTRL_PDOWN]) begin
                    next_cur.state = ST_POWERDOWN;
                end else if (!cur.actFilt && stbyEnabled) begin
                    next_cur.state = ST_STANDBY;
                end
            end
            default: begin
                next_cur.state = ST_POWERDOWN;
            end
        endcase

        // lanes driven only when active; else high impedance
        next_cur.laneEn = (next_cur.state == ST_ACTIVE)
            ? {LANES{1'b1}} : {LANES{1'b0}};
        // indicator pulled low only while active with standby on
        next_cur.flagOe = (next_cur.state == ST_ACTIVE)
            && stbyEnabled;

        // coupling selection
        acSel  = regMode ? cur.ctrl[`CTRL_AC_BIT] : cur.acQ;
        legSel = cur.legQ;

        // termination
        if (!regMode) begin
            if (acSel) begin
                termSel = (linkInfo.linkVer == LINK_V14)
                    ? TERM_V150 : TERM_V50;
            end else if (linkInfo.linkVer != LINK_V14) begin
                termSel = TERM_P100;
            end else if (legSel) begin
                termSel = TERM_P300;
            end else if (linkInfo.aboveTerm300Limit) begin
                termSel = TERM_P300;
            end else if (linkInfo.belowOpenLimit) begin
                termSel = TERM_OPEN;
            end else begin
                termSel = cur.cfg.term;  // hysteresis band: hold
            end
        end else if (acSel) begin
            case (cur.termCode)
                2'h3: termSel = TERM_V50;
                2'h2: termSel = (linkInfo.linkVer == LINK_V14)
                    ? TERM_V150 : TERM_V50;
                default: termSel = TERM_V150;
            endcase
        end else begin
            case (cur.termCode)
                2'h0: termSel = TERM_OPEN;
                2'h1: termSel = TERM_P300;
                2'h3: termSel = TERM_P100;
                default: begin
                    if (linkInfo.linkVer != LINK_V14) begin
                        termSel = TERM_P100;
                    end else if (cur.ctrl[`CTRL_LEG_AUTO]) begin
                        termSel = TERM_P300;
                    end else if (linkInfo.aboveTerm300Limit) begin
                        termSel = TERM_P300;
                    end else if (linkInfo.belowOpenLimit) begin
                        termSel = TERM_OPEN;
                    end else begin
                        termSel = cur.cfg.term;
                    end
                end
            endcase
        end

        // emphasis: snooped ffe on frl, strap otherwise
        if (linkInfo.linkVer == LINK_V21) begin
            case (linkInfo.snoopedFfeLevel)
                2'h0: emphSel = EMPH_DE25;
                2'h1: emphSel = EMPH_DE35;
                2'h2: emphSel = EMPH_DE37;
                default: emphSel = EMPH_DE46;
            endcase
        end else begin
            case (straps.emphasisStrap)
                LVL_LOW:  emphSel = EMPH_PRE35;
                LVL_R:    emphSel = EMPH_DE25;
                LVL_F:    emphSel = EMPH_0DB;
                default:  emphSel = EMPH_PRE60;
            endcase
        end

        // adaptive eq offset only with linearity F or high
        eqOffSel = 3'h0;
        if (straps.linearityStrap == LVL_F
                || straps.linearityStrap == LVL_HIGH) begin
            case (straps.emphasisStrap)
                LVL_LOW: eqOffSel = 3'h1;
                LVL_R:   eqOffSel = 3'h4;
                LVL_F:   eqOffSel = 3'h0;
                default: eqOffSel = 3'h2;
            endcase
        end

        next_cur.cfg.acBias    = acSel;
        next_cur.cfg.term      = termSel;
        next_cur.cfg.adaptiveEqOffset = eqOffSel;
        // emphasis data lanes in limited mode, clock lane too on frl
        next_cur.cfg.dataEmph  = linkInfo.limitedMode
            ? emphSel : EMPH_0DB;
        next_cur.cfg.clkEmph   = (linkInfo.limitedMode
            && linkInfo.linkVer == LINK_V21) ? emphSel : EMPH_0DB;
        // slew adjustable only in register mode and limited mode
        next_cur.cfg.slewAdjust = regMode && linkInfo.limitedMode;
        next_cur.cfg.slewClk   = next_cur.cfg.slewAdjust
            ? cur.slew[`SLEW_CLK_LSB +: 3] : 3'h0;
        // software range is its own duty; no clamping here
        if (!next_cur.cfg.slewAdjust) begin
            next_cur.cfg.slewData = 3'h0;
        end else if (linkInfo.linkVer == LINK_V14) begin
            next_cur.cfg.slewData = cur.slew[`EDGE_3G_LSB +: 3];
        end else if (linkInfo.linkVer == LINK_V20) begin
            next_cur.cfg.slewData = cur.slew[`EDGE_6G_LSB +: 3];
        end else begin
            next_cur.cfg.slewData = cur.slew[`SLEW_HR_LSB +: 3];
        end

        // register writes
        if (regWr) begin
            if (regAddr == `OFS_CTRL) begin
                next_cur.ctrl = regWrData[7:0];
            end else if (regAddr == `OFS_TERM) begin
                next_cur.termCode = regWrData[1:0];
            end else if (regAddr == `OFS_SLEW) begin
                next_cur.slew = regWrData[11:0];
            end
        end

        // register reads, data one cycle later; unmapped read zero
        next_cur.rdData = 16'h0000;
        if (regRd) begin
            if (regAddr == `OFS_CTRL) begin
                next_cur.rdData = {8'h00, cur.ctrl};
            end else if (regAddr == `OFS_TERM) begin
                next_cur.rdData = {14'h0000, cur.termCode};
            end else if (regAddr == `OFS_SLEW) begin
                next_cur.rdData = {4'h0, cur.slew};
            end else if (regAddr == `OFS_STATUS) begin
                next_cur.rdData = {12'h000, cur.actFilt, cur.state};
            end else if (regAddr == `OFS_SETTINGS) begin
                next_cur.rdData = {cur.cfg.adaptiveEqOffset, cur.cfg.dataEmph,
                    cur.cfg.clkEmph, cur.cfg.term, cur.cfg.acBias,
                    cur.cfg.slewAdjust, 2'h0};
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur          <= '0;
            cur.state    <= ST_POWERDOWN;
            cur.ctrl     <= `CTRL_RESET;  // power down in register mode
            cur.termCode <= `TERM_RESET;
            cur.slew     <= `SLEW_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign regRdData               = cur.rdData;
    assign outCfg                  = cur.cfg;
    assign laneOutEn               = cur.laneEn;
    assign signal_present_flag_out = 1'b0;  // open drain: only pulls low
    assign signal_present_flag_oe  = cur.flagOe;

    // checks
    a_lanes_hiz: assert property (
        @(posedge clk) disable iff (!arst_n)
        cur.state != ST_ACTIVE |-> laneOutEn == '0)
        else $error("lanes driven outside active state");
    a_flag_active: assert property (
        @(posedge clk) disable iff (!arst_n)
        signal_present_flag_oe |-> cur.state == ST_ACTIVE)
        else $error("indicator low outside active state");
    a_wake_on_act: assert property (
        @(posedge clk) disable iff (!arst_n)
        (cur.state == ST_STANDBY && cur.actFilt
         && !(regMode && cur.ctrl[`CTRL_PDOWN]))
        |=> cur.state == ST_ACTIVE)
        else $error("no wake on activity");
    a_sleep_on_loss: assert property (
        @(posedge clk) disable iff (!arst_n)
        (cur.state == ST_ACTIVE && !cur.actFilt && stbyEnabled
         && !(regMode && cur.ctrl[`CTRL_PDOWN]))
        |=> cur.state == ST_STANDBY)
        else $error("no standby on activity loss");
    a_filter_hold: assert property (
        @(posedge clk) disable iff (!arst_n)
        $changed(cur.actFilt)
        |-> $past(cur.filtCnt) == 4'(FILTER_CYC - 1))
        else $error("filter changed early");
    a_emph_clk: assert property (
        @(posedge clk) disable iff (!arst_n)
        $past(linkInfo.linkVer) != LINK_V21
        |-> outCfg.clkEmph == EMPH_0DB)
        else $error("clock lane emphasis outside frl");
    a_ffe_map: assert property (
        @(posedge clk) disable iff (!arst_n)
        (linkInfo.linkVer == LINK_V21 && linkInfo.limitedMode
         && linkInfo.snoopedFfeLevel == 2'h3)
        |=> outCfg.dataEmph == EMPH_DE46)
        else $error("ffe level 3 mapping wrong");
    a_strap_ac_term: assert property (
        @(posedge clk) disable iff (!arst_n)
        (!regMode && cur.acQ && linkInfo.linkVer == LINK_V20)
        |=> outCfg.term == TERM_V50)
        else $error("strap ac v2 termination wrong");
    a_slew_fixed: assert property (
        @(posedge clk) disable iff (!arst_n)
        !$past(regMode) |-> outCfg.slewClk == 3'h0)
        else $error("slew changed in strap mode");
    a_rd_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (regRd && regAddr > `OFS_SETTINGS) |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");

    c_wake: cover property (@(posedge clk) disable iff (!arst_n)
        cur.state == ST_STANDBY ##1 cur.state == ST_ACTIVE);
    c_sleep: cover property (@(posedge clk) disable iff (!arst_n)
        cur.state == ST_ACTIVE ##1 cur.state == ST_STANDBY);
    c_powerdown: cover property (@(posedge clk) disable iff (!arst_n)
        cur.state == ST_ACTIVE ##1 cur.state == ST_POWERDOWN);
    c_frl_emph: cover property (@(posedge clk) disable iff (!arst_n)
        outCfg.clkEmph == EMPH_DE37);

endmodule // redriver_output_control
`default_nettype wire

// ### dv/link_far_side.sv
/*
 * far side model: link source activity per lane and the board
 * pull-up on the open-drain signal-present pin.
 * assumes: the bench commands activity levels synchronously to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module link_far_side (
    // activity commands from the bench
    input  wire logic actClk,
    input  wire logic actLane2,
    // open-drain indicator from the block
    input  wire logic flagOut,
    input  wire logic flagOe,
    // towards the block and the board
    output logic      clkLaneActive,
    output logic      data_lane2_in,
    output logic      flagPin
);
    // source transmits on a lane only while commanded
    assign clkLaneActive = actClk;
    assign data_lane2_in = actLane2;
    // released pin floats up through the pull-up, never a stale value
    assign flagPin = flagOe ? flagOut : 1'b1;
endmodule // link_far_side

`default_nettype wire

// ### dv/redriver_output_control_tb.sv
/*
 * self-checking bench for the redriver output control block.
 * assumes: package compiled first, register header on include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "redriver_output_regs.svh"

module redriver_output_control_tb
    import redriver_output_pkg::*;
;
    logic          clk       = 1'b0;
    logic          arst_n    = 1'b0;
    logic          regMode   = 1'b1;
    strap_type     straps    = '0;
    link_info_type linkInfo  = '0;
    logic [3:0]    regAddr   = 4'h0;
    logic [15:0]   regWrData = 16'h0000;
    logic          regWr     = 1'b0;
    logic          regRd     = 1'b0;
    logic          actClk    = 1'b0;
    logic          actLane2  = 1'b0;
    logic          clkLaneActive, data_lane2_in, flagOut, flagOe, flagPin;
    logic [15:0]   regRdData;
    logic [3:0]    laneOutEn;
    out_cfg_type   outCfg;
    wire logic [6:0] slewOut = {outCfg.slewAdjust, outCfg.slewClk,
                                outCfg.slewData};
    wire logic [2:0] termNow = outCfg.term;
    int            failures  = 0;
    int            checked   = 0;
    // {swap, version, watches lane 2}
    logic [3:0]  mon [6] = '{4'b0_00_0, 4'b0_01_0, 4'b0_10_1,
                             4'b1_00_1, 4'b1_01_1, 4'b1_10_0};
    // {regmode, ac, legacy, code, version, below open limit, term}
    logic [10:0] trm [19] = '{
        11'b1_0_0_00_01_1_000, 11'b1_0_0_01_01_1_001, 11'b1_0_0_11_00_1_010,
        11'b1_0_0_10_01_1_010, 11'b1_0_0_10_10_1_010, 11'b1_0_1_10_00_1_001,
        11'b1_0_0_10_00_1_000, 11'b1_0_0_10_00_0_001, 11'b1_1_0_00_01_1_011,
        11'b1_1_0_01_01_1_011, 11'b1_1_0_11_00_1_100, 11'b1_1_0_10_00_1_011,
        11'b1_1_0_10_10_1_100, 11'b0_0_0_00_01_1_010, 11'b0_0_1_00_00_1_001,
        11'b0_0_0_00_00_1_000, 11'b0_0_0_00_00_0_001, 11'b0_1_0_00_00_1_011,
        11'b0_1_0_00_01_1_100};
    // {limited, version, emphasis, linearity, ffe, data, clock, offset}
    logic [17:0] emt [9] = '{
        18'b1_00_00_10_00_001_000_001, 18'b1_00_01_10_00_011_000_100,
        18'b1_01_10_10_00_000_000_000, 18'b1_01_11_10_00_010_000_010,
        18'b0_00_11_01_00_000_000_000, 18'b1_10_10_00_00_011_011_000,
        18'b1_10_10_00_01_100_100_000, 18'b1_10_10_00_10_101_101_000,
        18'b1_10_10_00_11_110_110_000};

    // 100 ns clock
    always #50 clk = ~clk;

    redriver_output_control #(.LANES(4)) dut (
        .clk(clk), .arst_n(arst_n), .regMode(regMode), .straps(straps),
        .clkLaneActive(clkLaneActive), .data_lane2_in(data_lane2_in),
        .linkInfo(linkInfo), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .outCfg(outCfg), .laneOutEn(laneOutEn),
        .signal_present_flag_out(flagOut), .signal_present_flag_oe(flagOe));

    link_far_side far (
        .actClk(actClk), .actLane2(actLane2), .flagOut(flagOut),
        .flagOe(flagOe), .clkLaneActive(clkLaneActive),
        .data_lane2_in(data_lane2_in), .flagPin(flagPin));

    // register words read back
    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pins and analog settings
    task automatic chkOut(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // wait n edges, then step past them so registered outputs settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chkWord(regRdData, exp);
    endtask

    // bounded wait on the lane enables; running out ends the run
    task automatic waitLanes(input logic [3:0] exp);
        int i;
        i = 0;
        while (laneOutEn !== exp && i < 20) begin
            cyc(1);
            i++;
        end
        chkOut(laneOutEn, exp);
        // a timed-out wait is already counted as a mismatch
        if (laneOutEn !== exp) test_done();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        // register mode starts powered down with standby on
        rd(`OFS_CTRL, 16'h0008);
        rd(`OFS_TERM, 16'h0002);
        rd(`OFS_SLEW, 16'h0000);
        rd(`OFS_STATUS, 16'h0001);
        rd(4'hf, 16'h0000);
        wr(`OFS_STATUS, 16'hffff);
        rd(`OFS_STATUS, 16'h0001);
        wr(`OFS_CTRL, 16'h0000);
        rd(`OFS_STATUS, 16'h0002);
        chkOut(laneOutEn, 8'h00);
        chkOut(flagPin, 8'h01);
        $display("done: reset and registers");
        // monitored lane follows version and swap
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            linkInfo.laneSwap <= mon[k][3];
            linkInfo.linkVer <= link_ver_type'(mon[k][2:1]);
            {actLane2, actClk} <= {~mon[k][0], mon[k][0]};
            cyc(12);
            chkOut(laneOutEn, 8'h00);
            @(posedge clk);
            {actLane2, actClk} <= {mon[k][0], ~mon[k][0]};
            waitLanes(4'hf);
            chkOut(flagPin, 8'h00);
            rd(`OFS_STATUS, 16'h000c);
            @(posedge clk);
            {actLane2, actClk} <= 2'b00;
            waitLanes(4'h0);
            chkOut(flagPin, 8'h01);
        end
        $display("done: activity detect");
        // a short burst must not wake the outputs
        @(posedge clk);
        linkInfo <= '0;
        actClk <= 1'b1;
        repeat (2) @(posedge clk);
        actClk <= 1'b0;
        cyc(12);
        chkOut(laneOutEn, 8'h00);
        // standby inhibited: outputs on, indicator left released
        wr(`OFS_CTRL, 16'h0001);
        waitLanes(4'hf);
        chkOut(flagPin, 8'h01);
        wr(`OFS_CTRL, 16'h0000);
        waitLanes(4'h0);
        $display("done: glitch and inhibit");
        // slew fields written, read back and passed through unclamped
        @(posedge clk);
        linkInfo.limitedMode <= 1'b1;
        linkInfo.linkVer <= LINK_V20;
        wr(`OFS_SLEW, 16'h0fab);
        rd(`OFS_SLEW, 16'h0fab);
        cyc(3);
        chkOut(slewOut, 8'h5e);
        // data field follows the link generation
        @(posedge clk);
        linkInfo.linkVer <= LINK_V14;
        cyc(3);
        chkOut(slewOut, 8'h5d);
        @(posedge clk);
        linkInfo.linkVer <= LINK_V21;
        cyc(3);
        chkOut(slewOut, 8'h5f);
        @(posedge clk);
        linkInfo.limitedMode <= 1'b0;
        cyc(3);
        chkOut(slewOut, 8'h00);
        @(posedge clk);
        linkInfo.limitedMode <= 1'b1;
        regMode <= 1'b0;
        cyc(3);
        chkOut(slewOut, 8'h00);
        $display("done: slew");
        // termination and bias, register then strap mode
        for (int k = 0; k < 19; k++) begin
            @(posedge clk);
            regMode <= trm[k][10];
            straps.acCoupleStrap <= trm[k][9];
            straps.legacyTermStrap <= trm[k][8];
            linkInfo.linkVer <= link_ver_type'(trm[k][5:4]);
            linkInfo.belowOpenLimit <= trm[k][3];
            linkInfo.aboveTerm300Limit <= ~trm[k][3];
            wr(`OFS_CTRL, {13'h0, trm[k][8], trm[k][9], 1'b0});
            wr(`OFS_TERM, {14'h0, trm[k][7:6]});
            cyc(6);
            chkOut(termNow, trm[k][2:0]);
            chkOut(outCfg.acBias, trm[k][9]);
        end
        $display("done: termination");
        // emphasis and equaliser offset from straps and snooped level
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            linkInfo.limitedMode <= emt[k][17];
            linkInfo.linkVer <= link_ver_type'(emt[k][16:15]);
            straps.emphasisStrap <= level4_type'(emt[k][14:13]);
            straps.linearityStrap <= level4_type'(emt[k][12:11]);
            linkInfo.snoopedFfeLevel <= emt[k][10:9];
            cyc(6);
            chkOut(outCfg.dataEmph, emt[k][8:6]);
            chkOut(outCfg.clkEmph, emt[k][5:3]);
            chkOut(outCfg.adaptiveEqOffset, emt[k][2:0]);
        end
        $display("done: emphasis");
        test_done();
    end
endmodule // redriver_output_control_tb

`default_nettype wire
